// file: logic/sttc_params.svh
`ifndef STTC_PARAMS_SVH
`define STTC_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define STTC_ADDR_TICK 8'h00
`define STTC_ADDR_TOP 8'h01
`define STTC_ADDR_PWR 8'h02
`define STTC_ADDR_STORAGE 8'h03

// ****************************************
// field positions
// ****************************************
`define STTC_TOP_FILTER 7
`define STTC_TOP_LINK 5
`define STTC_TOP_STORE 4
`define STTC_TOP_SUPPLY 3
`define STTC_TOP_TEST 2
`define STTC_TOP_RESET 1
`define STTC_TOP_INIT 0
`define STTC_PWR_RAIL_LOW 7
`define STTC_PWR_BUS_LOW 6
`define STTC_PWR_RAIL_HIGH 5
`define STTC_PWR_ANALOG 3
`define STTC_PWR_DIGITAL 2
`define STTC_PWR_OTP 1
`define STTC_PWR_LOOP 0

// ****************************************
// reset values
// ****************************************
`define STTC_TICK_RST 8'h00
`define STTC_PWR_RST 8'h00
`define STTC_RESET_FLAG_RST 1'b1
`define STTC_INIT_FLAG_RST 1'b1

// ****************************************
// protocol select codes
// ****************************************
`define STTC_PROTO_DSI3_A 3'h0
`define STTC_PROTO_DSI3_B 3'h3
`define STTC_PROTO_PSI5_A 3'h1
`define STTC_PROTO_PSI5_B 3'h5

// ****************************************
// timing
// ****************************************
`define STTC_CLK_PERIOD_NS 10
`define STTC_TICK_PERIOD_US 100
`define STTC_TICK_CYCLES ((`STTC_TICK_PERIOD_US * 1000) / `STTC_CLK_PERIOD_NS)
`define STTC_RCV_TIME_US 1000
`define STTC_RCV_TICKS ((`STTC_RCV_TIME_US + `STTC_TICK_PERIOD_US - 1) / `STTC_TICK_PERIOD_US)
`define STTC_DV_TIME_US 2000
`define STTC_DV_TICKS ((`STTC_DV_TIME_US + `STTC_TICK_PERIOD_US - 1) / `STTC_TICK_PERIOD_US)

`endif

// file: logic/sttc_pkg.sv
package sttc_pkg;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sttc_req_s;

	typedef struct packed {
		logic buffer_rail_low_flag;
		logic bus_input_low_flag;
		logic buffer_rail_high_flag;
		logic analog_regulator_fault;
		logic digital_regulator_fault;
		logic otp_regulator_fault;
		logic perimeter_loop_break_flag;
	} sttc_pwr_mon_s;

	typedef struct packed {
		logic abs_pressure_over;
		logic abs_pressure_under;
		logic selftest_incomplete;
		logic common_mode_fault;
		logic selftest_fault;
	} sttc_dsp_s;

	typedef struct packed {
		logic factory_otp_fault;
		logic user_otp_fault;
		logic user_array_fault;
		logic user_otp_write_active;
		logic thermal_fault;
	} sttc_store_s;

	// ****************************************
	// supply recovery sequence
	// ****************************************
	typedef enum logic [2:0] {
		SUP_NORMAL = 3'b001,
		SUP_HOLD = 3'b010,
		SUP_REPORT = 3'b100
	} sttc_sup_e;

endpackage : sttc_pkg

// file: logic/sttc_tick_timer.sv
module sttc_tick_timer #(
	parameter int W = 8,
	parameter int RST_VAL = 0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic reload,
	input wire logic [W-1:0] load_val,
	output logic [W-1:0] count_r
);

	if (W < 1 || RST_VAL < 0 || RST_VAL >= (1 << W)) begin : g_bad_cfg
		$error("sttc_tick_timer: width or reset value out of range");
	end

	// reload dominates so a live fault never lets the count drift down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= W'(RST_VAL);
		end else if (reload) begin
			count_r <= load_val;
		end else if (tick && count_r != '0) begin
			count_r <= count_r - W'(1);
		end
	end

endmodule : sttc_tick_timer

// file: logic/sttc_regs.sv
`include "sttc_params.svh"

module sttc_regs
	import sttc_pkg::*;
#(
	parameter int TICK_DIV = `STTC_TICK_CYCLES,
	parameter int RCV_TICKS = `STTC_RCV_TICKS,
	parameter int DV_TICKS = `STTC_DV_TICKS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire sttc_pkg::sttc_req_s reg_req,
	output logic [7:0] rdata_r,
	output logic rvalid_r,
	output logic rd_refused_r,
	input wire logic [2:0] protocol_select,
	input wire logic psi5_diag_mode,
	input wire logic power_fault_hold_select,
	input wire sttc_pkg::sttc_pwr_mon_s pwr_mon,
	input wire sttc_pkg::sttc_dsp_s dsp_stat,
	input wire logic osc_training_fault,
	input wire sttc_pkg::sttc_store_s store_stat,
	input wire logic factory_test_flag,
	input wire logic [7:0] channel_user_config,
	input wire logic tx_err_report,
	input wire logic resp_slot,
	output logic tx_enable_r,
	output logic tx_error_code_r,
	output logic storage_clear_r
);

	import sttc_pkg::*;

	localparam int PW = $clog2(TICK_DIV);

	if (TICK_DIV < 2 || RCV_TICKS < 1 || RCV_TICKS > 255 ||
		DV_TICKS < 1 || DV_TICKS > 255) begin : g_bad_cfg
		$error("sttc_regs: prescaler or timer length out of range");
	end

	// ****************************************
	// supply monitor synchroniser
	// ****************************************
	localparam int NMON = $bits(sttc_pwr_mon_s);
	logic [NMON-1:0] mon_meta_r;
	logic [NMON-1:0] mon_sync_r;

	for (genvar i = 0; i < NMON; i++) begin : g_sync
		// analog comparators are asynchronous to the oscillator
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mon_meta_r[i] <= 1'b0;
				mon_sync_r[i] <= 1'b0;
			end else begin
				mon_meta_r[i] <= pwr_mon[i];
				mon_sync_r[i] <= mon_meta_r[i];
			end
		end
	end

	sttc_pwr_mon_s mon;
	logic live_fault;
	assign mon = sttc_pwr_mon_s'(mon_sync_r);
	assign live_fault = |mon_sync_r;

	// ****************************************
	// mode decode
	// ****************************************
	logic dsi3_mode;
	logic read_allowed;
	logic dsi3_report_mode;

	assign dsi3_mode = (protocol_select == `STTC_PROTO_DSI3_A) ||
		(protocol_select == `STTC_PROTO_DSI3_B);
	assign read_allowed = dsi3_mode || psi5_diag_mode;
	// any code other than the DSI3 pair, and the DSI3 pair with power_fault_hold_select set, falls into the muting behaviour
	assign dsi3_report_mode = dsi3_mode && !power_fault_hold_select;

	// ****************************************
	// access decode
	// ****************************************
	logic rd_ok;
	logic rd_top;
	logic rd_pwr;
	logic rd_store;

	assign rd_ok = reg_req.rd && read_allowed;
	assign rd_top = rd_ok && reg_req.addr == `STTC_ADDR_TOP;
	assign rd_pwr = rd_ok && reg_req.addr == `STTC_ADDR_PWR;
	assign rd_store = rd_ok && reg_req.addr == `STTC_ADDR_STORAGE;

	// ****************************************
	// prescaler and tick counter
	// ****************************************
	logic [PW-1:0] presc_r;
	logic tick_r;
	logic [7:0] tick_count_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_r <= '0;
			tick_r <= 1'b0;
		end else if (presc_r == PW'(TICK_DIV - 1)) begin
			presc_r <= '0;
			tick_r <= 1'b1;
		end else begin
			presc_r <= presc_r + PW'(1);
			tick_r <= 1'b0;
		end
	end

	// wraps on its own; writes have no path in here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_count_r <= `STTC_TICK_RST;
		end else if (tick_r) begin
			tick_count_r <= tick_count_r + 8'h01;
		end
	end

	// ****************************************
	// recovery timer
	// ****************************************
	logic [7:0] rcv_count_r;
	logic rcv_zero;

	sttc_tick_timer #(
		.W(8),
		.RST_VAL(0)
	) u_rcv_timer (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick_r),
		.reload(live_fault),
		.load_val(8'(RCV_TICKS)),
		.count_r(rcv_count_r)
	);

	assign rcv_zero = (rcv_count_r == 8'h00) && !live_fault;

	// ****************************************
	// supply recovery sequence
	// ****************************************
	sttc_sup_e sup_r;
	sttc_sup_e sup_nxt;

	always_comb begin
		sup_nxt = sup_r;
		unique case (sup_r)
			SUP_NORMAL: begin
				if (live_fault) begin
					sup_nxt = SUP_HOLD;
				end
			end
			SUP_HOLD: begin
				if (rcv_zero) begin
					sup_nxt = dsi3_report_mode ? SUP_REPORT : SUP_NORMAL;
				end
			end
			SUP_REPORT: begin
				if (live_fault) begin
					sup_nxt = SUP_HOLD;
				end else if (resp_slot) begin
					sup_nxt = SUP_NORMAL;
				end
			end
			default: begin
				sup_nxt = SUP_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sup_r <= SUP_NORMAL;
			tx_enable_r <= 1'b1;
			tx_error_code_r <= 1'b0;
		end else begin
			sup_r <= sup_nxt;
			tx_enable_r <= (sup_nxt != SUP_HOLD);
			tx_error_code_r <= (sup_nxt == SUP_REPORT);
		end
	end

	// ****************************************
	// power fault flags
	// ****************************************
	logic [7:0] pwr_r;
	logic [7:0] pwr_set;
	logic pwr_clear;

	always_comb begin
		pwr_set = '0;
		pwr_set[`STTC_PWR_RAIL_LOW] = mon.buffer_rail_low_flag;
		pwr_set[`STTC_PWR_BUS_LOW] = mon.bus_input_low_flag;
		pwr_set[`STTC_PWR_RAIL_HIGH] = mon.buffer_rail_high_flag;
		pwr_set[`STTC_PWR_ANALOG] = mon.analog_regulator_fault;
		pwr_set[`STTC_PWR_DIGITAL] = mon.digital_regulator_fault;
		pwr_set[`STTC_PWR_OTP] = mon.otp_regulator_fault;
		pwr_set[`STTC_PWR_LOOP] = mon.perimeter_loop_break_flag;
	end

	// reading early would lose the fault, so DSI3 clears wait for timer zero
	assign pwr_clear = dsi3_report_mode ?
		(rcv_zero && (rd_pwr || tx_err_report)) :
		(rcv_zero && sup_r == SUP_HOLD);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_r <= `STTC_PWR_RST;
		end else if (pwr_clear) begin
			pwr_r <= pwr_set;
		end else begin
			pwr_r <= pwr_r | pwr_set;
		end
	end

	// ****************************************
	// reset and init flags
	// ****************************************
	logic reset_flag_r;
	logic init_flag_r;
	logic [3:0] cfg_hi_r;
	logic cfg_seen_r;
	logic cfg_change;
	logic [7:0] dv_count_r;

	// a report in the same cycle as the reset release cannot exist
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_flag_r <= `STTC_RESET_FLAG_RST;
		end else if (rd_top || tx_err_report) begin
			reset_flag_r <= 1'b0;
		end
	end

	// first clocked cycle captures the config, so no change is seen at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_hi_r <= 4'h0;
			cfg_seen_r <= 1'b0;
		end else begin
			cfg_hi_r <= channel_user_config[7:4];
			cfg_seen_r <= 1'b1;
		end
	end

	assign cfg_change = cfg_seen_r && (cfg_hi_r != channel_user_config[7:4]);

	sttc_tick_timer #(
		.W(8),
		.RST_VAL(DV_TICKS)
	) u_dv_timer (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick_r),
		.reload(cfg_change),
		.load_val(8'(DV_TICKS)),
		.count_r(dv_count_r)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_flag_r <= `STTC_INIT_FLAG_RST;
		end else if (cfg_change) begin
			init_flag_r <= 1'b1;
		end else if (dv_count_r == 8'h00) begin
			init_flag_r <= 1'b0;
		end
	end

	// ****************************************
	// second status register clear strobe
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			storage_clear_r <= 1'b0;
		end else begin
			storage_clear_r <= rd_store || tx_err_report;
		end
	end

	// ****************************************
	// top status, live filter and storage summaries, supply summary from the latched power flags
	// ****************************************
	logic [7:0] top_status;

	always_comb begin
		top_status = 8'h00;
		top_status[`STTC_TOP_FILTER] = |dsp_stat;
		top_status[`STTC_TOP_LINK] = osc_training_fault;
		top_status[`STTC_TOP_STORE] = |store_stat;
		top_status[`STTC_TOP_SUPPLY] = |pwr_r;
		top_status[`STTC_TOP_TEST] = factory_test_flag;
		top_status[`STTC_TOP_RESET] = reset_flag_r;
		top_status[`STTC_TOP_INIT] = init_flag_r;
	end

	// ****************************************
	// read port
	// ****************************************
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_req.addr)
			`STTC_ADDR_TICK: rd_mux = tick_count_r;
			`STTC_ADDR_TOP: rd_mux = top_status;
			`STTC_ADDR_PWR: rd_mux = pwr_r;
			default: rd_mux = 8'h00;
		endcase
	end

	// writes get no answer and touch nothing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			rd_refused_r <= 1'b0;
		end else begin
			rvalid_r <= reg_req.rd;
			rd_refused_r <= reg_req.rd && !read_allowed;
			if (reg_req.rd) begin
				rdata_r <= read_allowed ? rd_mux : 8'h00;
			end
		end
	end

endmodule : sttc_regs

// file: tb/sttc_checker.sv
module sttc_checker
	import sttc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire sttc_pkg::sttc_req_s reg_req,
	input wire logic [7:0] rdata_r,
	input wire logic rvalid_r,
	input wire logic rd_refused_r,
	input wire logic [2:0] protocol_select,
	input wire logic psi5_diag_mode,
	input wire sttc_pkg::sttc_dsp_s dsp_stat,
	input wire logic osc_training_fault,
	input wire sttc_pkg::sttc_store_s store_stat,
	input wire logic resp_slot,
	input wire logic tx_enable_r,
	input wire logic tx_error_code_r,
	input wire logic storage_clear_r
);
	// ****************************************
	// read port and status relations
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic ok_mode;
	logic rd_top;
	assign ok_mode = (protocol_select == 3'h0) || (protocol_select == 3'h3) || psi5_diag_mode;
	assign rd_top = reg_req.rd && ok_mode && (reg_req.addr == 8'h01);

	a_read_answer: assert property (reg_req.rd |=> rvalid_r)
		else $error("read not answered");
	a_write_silent: assert property (!reg_req.rd |=> !rvalid_r)
		else $error("answer without a read");
	a_read_refused: assert property (reg_req.rd && !ok_mode |=> rd_refused_r && rdata_r == 8'h00)
		else $error("read outside allowed mode not refused");
	a_read_served: assert property (reg_req.rd && ok_mode |=> !rd_refused_r)
		else $error("read in allowed mode refused");
	a_filter_sum: assert property (rd_top |=> rdata_r[7] == |$past(dsp_stat))
		else $error("filter summary wrong");
	a_link_sum: assert property (rd_top |=> rdata_r[5] == $past(osc_training_fault))
		else $error("link summary wrong");
	a_store_sum: assert property (rd_top |=> rdata_r[4] == |$past(store_stat))
		else $error("storage summary wrong");
	a_store_clear: assert property (reg_req.rd && ok_mode && reg_req.addr == 8'h03 |=> storage_clear_r)
		else $error("second status read did not clear");
	a_report_once: assert property (tx_error_code_r && resp_slot |-> ##2 !tx_error_code_r)
		else $error("error code sent more than once");

	c_refused: cover property (reg_req.rd && !ok_mode);
	c_muted: cover property ($fell(tx_enable_r));
	c_reported: cover property (tx_error_code_r && resp_slot);
endmodule : sttc_checker

bind sttc_regs sttc_checker i_chk (.clk, .rst_n, .reg_req, .rdata_r, .rvalid_r, .rd_refused_r,
	.protocol_select, .psi5_diag_mode, .dsp_stat, .osc_training_fault, .store_stat,
	.resp_slot, .tx_enable_r, .tx_error_code_r, .storage_clear_r);

// file: tb/sttc_master.sv
module sttc_master (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tx_enable_r,
	input wire logic err_en,
	output logic resp_slot,
	output logic tx_err_report
);
	// ****************************************
	// response slots of the bus master
	// ****************************************
	logic [2:0] slot_cnt_r;

	// a slot every eighth cycle, granted only while the sensor may talk
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_cnt_r <= 3'h0;
			resp_slot <= 1'b0;
		end else begin
			slot_cnt_r <= slot_cnt_r + 3'h1;
			resp_slot <= tx_enable_r && (slot_cnt_r == 3'h7);
		end
	end
	// err_en marks a transmission whose status field carries the error
	assign tx_err_report = resp_slot && err_en;
endmodule : sttc_master

// file: tb/tb_top.sv
module tb_top
	import sttc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// stimulus and checks
	// ****************************************
	logic clk;
	logic rst_n;
	sttc_req_s req;
	logic [2:0] ps;
	logic diag, hold, osc, tflag, err_en, rvalid, refused, txen, txerr, sclr, slot, terr, rf;
	sttc_pwr_mon_s pm;
	sttc_dsp_s dsp;
	sttc_store_s st;
	logic [7:0] cfg, rdata, d, d2;
	int n_mismatch, total_checks;

	sttc_regs #(.TICK_DIV(4), .RCV_TICKS(2), .DV_TICKS(2)) i_dut (.clk(clk), .rst_n(rst_n),
		.reg_req(req), .rdata_r(rdata), .rvalid_r(rvalid), .rd_refused_r(refused),
		.protocol_select(ps), .psi5_diag_mode(diag), .power_fault_hold_select(hold),
		.pwr_mon(pm), .dsp_stat(dsp), .osc_training_fault(osc), .store_stat(st),
		.factory_test_flag(tflag), .channel_user_config(cfg), .tx_err_report(terr),
		.resp_slot(slot), .tx_enable_r(txen), .tx_error_code_r(txerr), .storage_clear_r(sclr));
	sttc_master i_master (.clk(clk), .rst_n(rst_n), .tx_enable_r(txen), .err_en(err_en),
		.resp_slot(slot), .tx_err_report(terr));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// answer lands on the taking edge itself and is read 1 ns after it
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk("rvalid", 8'h01, {7'h00, rvalid});
		v = rdata;
		rf = refused;
	endtask : rd

	task wt(input bit which, input logic val);
		int i;
		for (i = 0; i < 200 && ((which ? txerr : txen) !== val); i++) @(posedge clk) #1;
		if (i == 200) begin
			$display("MISMATCH %s expected %b seen %b", which ? "tx_error_code" : "tx_enable",
				val, which ? txerr : txen);
			n_mismatch++;
			close_out();
		end
	endtask : wt

	task t_boot;
		rd(8'h01, d);
		chk("top after reset", 8'h03, d);
		rd(8'h01, d);
		chk("reset flag", 8'h00, d & 8'h02);
		repeat (40) @(posedge clk);
		rd(8'h01, d);
		chk("init done", 8'h00, d);
		@(posedge clk) cfg <= 8'h50;
		rd(8'h01, d);
		chk("init restarted", 8'h01, d);
		repeat (40) @(posedge clk);
		cfg <= 8'h5f;
		rd(8'h01, d);
		chk("low config bits", 8'h00, d);
	endtask : t_boot

	task t_tick;
		rd(8'h00, d);
		@(posedge clk);
		req.wr <= 1'b1;
		req.wdata <= 8'hff;
		@(posedge clk) req.wr <= 1'b0;
		repeat (36) @(posedge clk);
		rd(8'h00, d2);
		chk("tick advance", 8'h0a, d2 - d);
	endtask : t_tick

	task t_refuse;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) ps <= i[0] ? 3'h5 : 3'h1;
			rd(8'h00, d);
			chk("refused", 8'h01, {7'h00, rf});
			chk("refused data", 8'h00, d);
		end
		@(posedge clk) diag <= 1'b1;
		rd(8'h00, d);
		chk("diag read", 8'h00, {7'h00, rf});
	endtask : t_refuse

	task t_summary;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			dsp <= 5'h01 << i;
			st <= 5'h10 >> i;
			osc <= i[0];
			tflag <= i[1];
			rd(8'h01, d);
			chk("top summary", 8'h90 | {2'b00, i[0], 2'b00, i[1], 2'b00}, d);
		end
		@(posedge clk);
		{dsp, st, osc, tflag} <= '0;
		rd(8'h03, d);
		chk("storage clear", 8'h01, {7'h00, sclr});
		rd(8'h40, d);
		chk("unmapped", 8'h00, d);
	endtask : t_summary

	task t_sup(input logic [2:0] p, input logic h, input logic en, input sttc_pwr_mon_s f,
		input logic [7:0] e);
		@(posedge clk);
		ps <= p;
		hold <= h;
		err_en <= en;
		pm <= f;
		// held well past the recovery time, so only a reload keeps the mute
		repeat (20) @(posedge clk);
		#1;
		chk("muted", 8'h00, {7'h00, txen});
		rd(8'h01, d);
		chk("supply summary", 8'h08, d);
		rd(8'h02, d);
		chk("power flags", e, d);
		@(posedge clk) pm <= '0;
		if ((p == 3'h3 || p == 3'h0) && !h) begin
			rd(8'h02, d);
			chk("no clear in recovery", e, d);
			wt(1, 1);
			chk("talking while reporting", 8'h01, {7'h00, txen});
			wt(1, 0);
			if (!en) begin
				rd(8'h02, d);
				chk("flags before clear", e, d);
			end
		end else begin
			wt(0, 1);
			chk("no error code", 8'h00, {7'h00, txerr});
		end
		rd(8'h02, d);
		chk("flags cleared", 8'h00, d);
	endtask : t_sup

	// a reset in mid-run must raise the reset and init flags again
	task t_reset;
		@(posedge clk) rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h01, d);
		chk("top after second reset", 8'h03, d);
	endtask : t_reset

	initial begin
		#200us;
		$display("MISMATCH run time expected end seen none");
		n_mismatch++;
		close_out();
	end

	initial begin
		req = '0;
		{ps, diag, hold, osc, tflag, err_en} = '0;
		ps = 3'h3;
		{pm, dsp, st} = '0;
		cfg = 8'h00;
		n_mismatch = 0;
		total_checks = 0;
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_boot();
		t_tick();
		t_refuse();
		t_summary();
		t_sup(3'h3, 1'b0, 1'b0, 7'h40, 8'h80);
		t_sup(3'h0, 1'b0, 1'b1, 7'h20, 8'h40);
		t_sup(3'h0, 1'b1, 1'b0, 7'h01, 8'h01);
		t_sup(3'h1, 1'b0, 1'b0, 7'h08, 8'h08);
		t_sup(3'h5, 1'b0, 1'b0, 7'h10, 8'h20);
		t_reset();
		close_out();
	end
endmodule : tb_top
